//--- tb/ccr_host_model.sv
// host side model driving the register port of the register pair
`timescale 1ns/1ps
module ccr_host_model (
  // clock
  input wire logic sys_clk,
  // register port towards the device
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  // ==========================================================
  // idle state at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // ==========================================================
  // one write strobe per byte; released data is inverted so a
  // stale byte can never pass for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // one read strobe per byte, data sampled by the caller after it
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask : rd
endmodule : ccr_host_model

//--- tb/charge_current_config_regs_tb_top.sv
// self-checking bench for the charge current register pair
`timescale 1ns/1ps
module charge_current_config_regs_tb_top;
  import ccr_pkg::*;
  // ==========================================================
  // clock, reset, port signals and model state
  logic sys_clk, rst_n, soft_rst, reg_wr, reg_rd, bc, frc;
  logic [7:0] reg_addr, reg_wdata, rdata;
  logic [5:0] fc;
  logic [3:0] pc;
  logic [2:0] tc;
  logic [12:0] fma;
  logic [11:0] pma, tma;
  int fails, num_checks, m_chg, m_pre, r;
  ccr_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  ccr_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .soft_rst(soft_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(rdata), .fast_chg_current(fc),
    .boost_cold_sel(bc), .force_reduced_current(frc),
    .precharge_current(pc), .termination_current(tc),
    .fast_chg_ma(fma), .precharge_ma(pma), .termination_ma(tma));
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // reference currents worked out from the field encodings
  function automatic int e_pre(int p);
    int c;
    int v;
    c = (p >> 4) & 15;
    v = (c < 2) ? 128 : (c < 5) ? 128 * c : 128 * (c + 1);
    return (m_chg & 1) ? v / 2 : v;
  endfunction : e_pre
  task automatic chk(string n, logic [15:0] s, int e);
    num_checks++;
    if (s !== 16'(e)) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", n, e, s);
    end
  endtask : chk
  task automatic check_all();
    int v;
    v = 512 + 64 * (m_chg >> 2);
    chk("fast code", 16'(fc), m_chg >> 2);
    chk("cold select", 16'(bc), (m_chg >> 1) & 1);
    chk("force", 16'(frc), m_chg & 1);
    chk("fast ma", 16'(fma), (m_chg & 1) ? v / 5 : v);
    chk("pre code", 16'(pc), m_pre >> 4);
    chk("pre ma", 16'(pma), e_pre(m_pre));
    chk("term code", 16'(tc), m_pre & 7);
    chk("term ma", 16'(tma), 128 + 128 * (m_pre & 7));
  endtask : check_all
  // write, update the model, let the mA outputs settle and compare
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    u_host.wr(a, d);
    if (a == CCR_ADDR_CHG) m_chg = d;
    if (a == CCR_ADDR_PRE) m_pre = d;
    @(posedge sys_clk);
    #1;
    check_all();
  endtask : wreg
  task automatic rreg(logic [7:0] a, int e);
    u_host.rd(a);
    #1;
    chk("read data", 16'(rdata), e);
  endtask : rreg
  task automatic defaults(int n);
    m_chg = 'h60;
    m_pre = 'h11;
    repeat (n) @(posedge sys_clk);
    #1;
    check_all();
  endtask : defaults
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // ==========================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #20000;
    fails++;
    stop_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    soft_rst = 1'b0;
    fails = 0;
    num_checks = 0;
    void'($urandom(9054));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    defaults(4);
    rreg(CCR_ADDR_CHG, 'h60);
    rreg(CCR_ADDR_PRE, 'h11);
    $display("test reset done");
    // every legal fast code, every precharge code, reserved bit kept 0
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      r = (r & ~1) | ((i >> 4) & 1); // force on for codes 16..31
      wreg(CCR_ADDR_CHG, 8'((i << 2) | (r & 3)));
      wreg(CCR_ADDR_PRE, 8'(((i & 15) << 4) | ((r >> 2) & 7)));
      rreg(CCR_ADDR_CHG, m_chg);
      rreg(CCR_ADDR_PRE, m_pre);
    end
    $display("test field sweep done");
    r = $urandom;
    wreg(8'(r | 4), 8'h00);
    rreg(8'(r | 4), 0);
    $display("test unmapped done");
    // soft reset in the very cycle of a write: the reset wins
    fork
      u_host.wr(CCR_ADDR_PRE, 8'h37);
      begin
        @(posedge sys_clk);
        soft_rst <= 1'b1;
        @(posedge sys_clk);
        soft_rst <= 1'b0;
      end
    join
    defaults(1);
    wreg(CCR_ADDR_PRE, 8'hf7);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    defaults(4);
    rreg(CCR_ADDR_PRE, 'h11);
    $display("test soft and hard reset done");
    stop_test();
  end
endmodule : charge_current_config_regs_tb_top

//--- verilog/ccr_cur_decode.sv
// code to milliamp decoder for the charge current fields
`timescale 1ns/1ps
module ccr_cur_decode import ccr_pkg::*; (
  // programmed codes
  input wire logic [5:0] fast_code,
  input wire logic [3:0] pre_code,
  input wire logic [2:0] term_code,
  input wire logic force_red,
  // effective currents in mA
  output logic [12:0] fast_ma,
  output logic [11:0] pre_ma,
  output logic [11:0] term_ma
);
  logic [12:0] fast_full; // programmed fast charge current
  logic [11:0] pre_full; // programmed precharge current

  // fast charge: offset plus binary weights
  assign fast_full = CCR_FAST_OFS_MA + 13'(fast_code) * CCR_FAST_STEP_MA;

  // precharge lookup; steps are not uniform below code 1000
  always_comb begin
    case (pre_code)
      4'h0, 4'h1: pre_full = 12'h080;
      4'h2: pre_full = 12'h100;
      4'h3: pre_full = 12'h180;
      4'h4: pre_full = 12'h200;
      4'h5: pre_full = 12'h300;
      4'h6: pre_full = 12'h380;
      4'h7: pre_full = 12'h400;
      // widen before the add, or code 1111 would wrap to zero
      default: pre_full = (12'(pre_code) + 12'h001) * CCR_PRE_STEP_MA;
    endcase
  end

  // force option: fifth of fast charge, half of precharge
  // the fifth truncates toward zero, so 2048 mA shows as 409 mA
  assign fast_ma = force_red ? 13'(fast_full / 13'h0005) : fast_full;
  assign pre_ma = force_red ? {1'b0, pre_full[11:1]} : pre_full;

  // termination: offset plus weights 512/256/128
  assign term_ma = CCR_TERM_OFS_MA + 12'(term_code) * CCR_TERM_STEP_MA;
endmodule : ccr_cur_decode

//--- verilog/ccr_pkg.sv
// constants for the charge current configuration register pair
// How it works
// - fast charge code bits 7:2, 512+64/LSB
// - fast charge code resets to 011000
// - bit 1 picks cold boost threshold
// - force bit cuts currents to 20%/50%
// - precharge code bits 7:4, lookup table
// - precharge code resets to 0001
// - termination code bits 2:0, 128 offset
// - termination code resets to 001
// - second register resets 00010001, bit3 reserved
// - first register resets 01100000, both RW
package ccr_pkg;
  // =========================================================
  // register addresses (register index on the internal port)
  localparam logic [7:0] CCR_ADDR_CHG = 8'h02;
  localparam logic [7:0] CCR_ADDR_PRE = 8'h03;
  // =========================================================
  // reset values
  localparam logic [7:0] CCR_RST_CHG = 8'h60;
  localparam logic [7:0] CCR_RST_PRE = 8'h11;
  localparam logic [7:0] CCR_UNMAPPED = 8'h00;
  // =========================================================
  // field positions
  localparam int CCR_FAST_LSB = 2;
  localparam int CCR_COLD_BIT = 1;
  localparam int CCR_FORCE_BIT = 0;
  localparam int CCR_PRE_LSB = 4;
  localparam int CCR_RSVD_BIT = 3;
  localparam int CCR_TERM_LSB = 0;
  // =========================================================
  // current scaling in mA
  localparam logic [12:0] CCR_FAST_OFS_MA = 13'h0200;
  localparam logic [12:0] CCR_FAST_STEP_MA = 13'h0040;
  localparam logic [5:0] CCR_FAST_MAX_CODE = 6'h27;
  localparam logic [11:0] CCR_PRE_STEP_MA = 12'h080;
  localparam logic [11:0] CCR_TERM_OFS_MA = 12'h080;
  localparam logic [11:0] CCR_TERM_STEP_MA = 12'h080;
endpackage : ccr_pkg

//--- verilog/ccr_regs.sv
// charge current control and precharge/termination register pair
`timescale 1ns/1ps
module ccr_regs import ccr_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register reset request from the configuration logic (same clock)
  input wire logic soft_rst,
  // register port from the serial slave (same clock)
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // settings to the charge loops
  output logic [5:0] fast_chg_current,
  output logic boost_cold_sel,
  output logic force_reduced_current,
  output logic [3:0] precharge_current,
  output logic [2:0] termination_current,
  // effective currents in mA
  output logic [12:0] fast_chg_ma,
  output logic [11:0] precharge_ma,
  output logic [11:0] termination_ma
);
  // =========================================================
  // reset release
  logic rst_s1_r; // first stage, read only by the second
  logic rst_s2_r; // synchronised active-high run level

  // release through two flops so the register pair and read data leave reset together
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // =========================================================
  // registers
  // both are plain read/write storage; nothing here checks a code, so a
  // fast charge code above 100111 is kept as written and the host must
  // keep away from it
  logic [7:0] chg_r; // charge current control
  logic [7:0] pre_r; // precharge/termination current
  logic wr_chg; // write hits the first register
  logic wr_pre; // write hits the second register

  assign wr_chg = reg_wr && (reg_addr == CCR_ADDR_CHG);
  assign wr_pre = reg_wr && (reg_addr == CCR_ADDR_PRE);

  // charge current control; soft reset wins over a write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_r <= CCR_RST_CHG;
    end else if (!rst_s2_r || soft_rst) begin
      chg_r <= CCR_RST_CHG;
    end else if (wr_chg) begin
      // codes above 100111 are stored as written
      chg_r <= reg_wdata;
    end
  end

  // precharge/termination; reserved bit is stored, no function
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= CCR_RST_PRE;
    end else if (!rst_s2_r || soft_rst) begin
      pre_r <= CCR_RST_PRE;
    end else if (wr_pre) begin
      pre_r <= reg_wdata;
    end
  end

  // =========================================================
  // read port: one cycle after the strobe, unmapped reads zero
  // the data holds between reads, so a slow host may pick it up late
  // a read in the cycle of a write to the same address sees the old byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= CCR_UNMAPPED;
    end else if (!rst_s2_r) begin
      reg_rdata <= CCR_UNMAPPED;
    end else if (reg_rd) begin
      case (reg_addr)
        CCR_ADDR_CHG: reg_rdata <= chg_r;
        CCR_ADDR_PRE: reg_rdata <= pre_r;
        default: reg_rdata <= CCR_UNMAPPED;
      endcase
    end
  end

  // =========================================================
  // field outputs
  // straight from the flops, so the loops never see a decoding glitch
  // the reserved bit 3 of the second register drives nothing
  assign fast_chg_current = chg_r[CCR_FAST_LSB +: 6];
  assign boost_cold_sel = chg_r[CCR_COLD_BIT];
  assign force_reduced_current = chg_r[CCR_FORCE_BIT];
  assign precharge_current = pre_r[CCR_PRE_LSB +: 4];
  assign termination_current = pre_r[CCR_TERM_LSB +: 3];

  // =========================================================
  // effective currents, registered so the loops see clean data
  // the cost is one more cycle of latency after every write or soft reset
  logic [12:0] fast_dec; // decoded fast charge
  logic [11:0] pre_dec; // decoded precharge
  logic [11:0] term_dec; // decoded termination

  ccr_cur_decode u_dec (
    .fast_code(fast_chg_current),
    .pre_code(precharge_current),
    .term_code(termination_current),
    .force_red(force_reduced_current),
    .fast_ma(fast_dec),
    .pre_ma(pre_dec),
    .term_ma(term_dec)
  );

  // one cycle behind the register contents
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_chg_ma <= 13'h0800; // 2048 mA
      precharge_ma <= 12'h080; // 128 mA
      termination_ma <= 12'h100; // 256 mA
    end else begin
      fast_chg_ma <= fast_dec;
      precharge_ma <= pre_dec;
      termination_ma <= term_dec;
    end
  end

  // =========================================================
  // checks
  // all of them sleep until the reset release has finished, since the
  // registers are forced to their defaults until then anyway
  default clocking ck @(posedge sys_clk); endclocking
  default disable iff (!rst_s2_r);

  // writes land one edge after the strobe unless a soft reset beats them
  chg_write_lands_a: assert property (
      wr_chg && !soft_rst |=> chg_r == $past(reg_wdata))
    else $error("charge register write lost");
  pre_write_lands_a: assert property (
      wr_pre && !soft_rst |=> pre_r == $past(reg_wdata))
    else $error("precharge register write lost");

  // a register changes only by its own write or by a reset
  chg_holds_a: assert property (
      !wr_chg && !soft_rst |=> $stable(chg_r))
    else $error("charge register changed without a write");
  pre_holds_a: assert property (
      !wr_pre && !soft_rst |=> $stable(pre_r))
    else $error("precharge register changed without a write");

  // defaults after a soft reset and when the reset release completes
  soft_reset_chg_a: assert property (
      soft_rst |=> chg_r == 8'h60)
    else $error("charge register not default after reset");
  soft_reset_pre_a: assert property (
      soft_rst |=> pre_r == 8'h11)
    else $error("precharge register not default after reset");
  release_default_a: assert property (
      $rose(rst_s2_r) |-> chg_r == CCR_RST_CHG && pre_r == CCR_RST_PRE)
    else $error("register pair not default after reset release");

  // read data is the register as it stood at the read edge
  read_chg_a: assert property (
      reg_rd && reg_addr == 8'h02 |=> reg_rdata == $past(chg_r))
    else $error("charge register read wrong");
  read_pre_a: assert property (
      reg_rd && reg_addr == 8'h03 |=> reg_rdata == $past(pre_r))
    else $error("precharge register read wrong");
  read_unmapped_a: assert property (
      reg_rd && reg_addr != 8'h02 && reg_addr != 8'h03 |=>
      reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  read_holds_a: assert property (
      !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // currents: one edge behind the codes they are worked out from
  fast_scale_a: assert property (
      ##1 !$past(force_reduced_current) |->
      fast_chg_ma == 13'h0200 + 13'($past(fast_chg_current)) * 13'h0040)
    else $error("fast charge current wrong");
  fast_fifth_a: assert property (
      ##1 $past(force_reduced_current) |-> fast_chg_ma ==
      (13'h0200 + 13'($past(fast_chg_current)) * 13'h0040) / 13'h0005)
    else $error("reduced fast charge current wrong");
  force_half_a: assert property (
      ##1 $past(force_reduced_current) && $past(precharge_current) == 4'h4
      |-> precharge_ma == 12'h100)
    else $error("reduced precharge current wrong");
  pre_table_a: assert property (
      ##1 !$past(force_reduced_current) && $past(precharge_current) == 4'h5
      |-> precharge_ma == 12'h300)
    else $error("precharge lookup wrong");
  pre_table_high_a: assert property (
      ##1 !$past(force_reduced_current) && $past(precharge_current) >= 4'h8
      |-> precharge_ma == 12'h480 +
      12'h080 * (12'($past(precharge_current)) - 12'h008))
    else $error("precharge upper range wrong");
  term_scale_a: assert property (
      ##1 $past(termination_current) == 3'h7 |-> termination_ma == 12'h400)
    else $error("termination current wrong");
  term_all_a: assert property (
      1'b1 |=> termination_ma ==
      12'h080 + 12'h080 * 12'($past(termination_current)))
    else $error("termination current off its code");

  // =========================================================
  // main scenarios
  cov_force_c: cover property (
      (wr_chg && reg_wdata[0]) ##[1:8] (reg_rd && reg_addr == 8'h02));
  cov_soft_c: cover property (wr_pre && soft_rst);
  cov_unmapped_c: cover property (
      reg_rd && reg_addr != 8'h02 && reg_addr != 8'h03);
  cov_pre_top_c: cover property (
      precharge_current == 4'hf && !force_reduced_current);
endmodule : ccr_regs
